/* logic/ras_pkg.sv */
// constants shared by the return address stack block
package ras_pkg;
  // stack geometry
  localparam int         PC_W      = 10;       // program counter width
  localparam int         ENTRIES   = 4;        // stack depth
  localparam int         SP_W      = 2;        // pointer width
  localparam int         HI_W      = 2;        // saved upper counter bits
  localparam int         LO_W      = 8;        // saved lower counter bits
  localparam int         GIE_BIT   = 7;        // interrupt enable position
  // register indexes, byte address is four times the index
  localparam logic [7:0] IDX_PTR   = 8'hDF;    // pointer and enable
  localparam logic [7:0] IDX_ENT0  = 8'hF0;    // entry 0 low, then high, ...
  localparam logic [7:0] IDX_ENTN  = 8'hF7;    // entry 3 high
  localparam int         APB_AW    = 12;       // apb address width
  // reset values
  localparam logic [1:0] SP_RST    = 2'h3;     // empty stack pointer
  localparam logic [9:0] PC_RST    = 10'h000;  // program start
  // defaults of the module parameters
  localparam int         DIV_DEF   = 4;        // core clocks per instruction
  localparam logic [9:0] IRQ_VEC_DEF = 10'h008;  // interrupt entry address
  localparam logic [7:0] BANK0     = 8'h00;    // direct access bank
  // entry used by a pointer value
  function automatic logic [1:0] entryOf(input logic [1:0] p);
    return 2'(2'h2 - p);
  endfunction
endpackage

/* logic/return_address_stack.sv */
// return address stack, program counter and data addressing with apb registers
`timescale 1ns/1ns
`default_nettype none
// Operation
// - four stack entries hold saved counters
// - stack pointer is two bits wide
// - entry keeps counter upper two, lower eight
// - push decrements pointer, pop increments it
// - push counter on call and interrupt entry
// - pops return values in last-in first-out order
// - enable bit seven resets zero, pointer resets ones
// - pointer level to entry mapping as tabled
// - returns load popped value into counter
// - pointer and entries readable writable, entries reset zero
// - direct mode moves memory and accumulator
// - indirect address is bank and location
// - ten bit counter resets to zero
module return_address_stack #(
  parameter int         CYC_DIV = ras_pkg::DIV_DEF,
  parameter logic [9:0] IRQ_VEC = ras_pkg::IRQ_VEC_DEF
)(
  // clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // apb slave
  input  wire logic [ras_pkg::APB_AW-1:0] paddr,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // sequencer requests, sampled at instrTick
  output logic                            instrTick,
  input  wire logic                       irqEntry,
  input  wire logic                       callEn,
  input  wire logic [9:0]                 callTarget,
  input  wire logic                       retEn,
  input  wire logic                       retiEn,
  input  wire logic                       jumpEn,
  input  wire logic [9:0]                 jumpTarget,
  output logic      [9:0]                 programCounter,
  output logic                            globalIrqEnable,
  // accumulator and data memory
  input  wire logic                       accLoad,
  input  wire logic [7:0]                 accValue,
  input  wire logic                       memDirect,
  input  wire logic                       memIndirect,
  input  wire logic                       memToMem,
  input  wire logic [7:0]                 directAddr,
  input  wire logic [7:0]                 bankPtr,
  input  wire logic [7:0]                 locPtr,
  input  wire logic [7:0]                 memRdata,
  output logic      [15:0]                dmAddr,
  output logic                            dmWe,
  output logic                            dmRe,
  output logic      [7:0]                 dmWdata,
  output logic      [7:0]                 accumulator
);

  // whole block state
  typedef struct packed {
    logic [1:0]       sp;       // stack pointer
    logic             global_irq_enable;      // global interrupt enable
    logic [3:0][1:0]  hi;       // saved upper counter bits
    logic [3:0][7:0]  lo;       // saved lower counter bits
    logic [9:0]       pc;       // program counter
    logic [7:0]       acc;      // accumulator
    logic [7:0]       div;      // instruction cycle divider
    logic [31:0]      rdata;    // apb read data
    logic [15:0]      dmAddr;   // data memory address
    logic             dmWe;     // memory write pulse
    logic             dmRe;     // memory read pulse
    logic [7:0]       dmWdata;  // memory write data
    logic             accPend;  // read result due next tick
  } st_t;

  st_t s_r;       // registered state
  st_t s_nxt;     // next state

  // is the byte address one of ours
  function automatic logic mapped(input logic [ras_pkg::APB_AW-1:0] a);
    logic [7:0] i;
    i = a[9:2];
    return (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
           ((i == ras_pkg::IDX_PTR) || ((i >= ras_pkg::IDX_ENT0) && (i <= ras_pkg::IDX_ENTN)));
  endfunction

  // read value of a mapped register, zero elsewhere
  function automatic logic [31:0] regRead(input logic [ras_pkg::APB_AW-1:0] a, input st_t s);
    logic [7:0] i;
    logic [2:0] o;
    i = a[9:2];
    o = 3'(i - ras_pkg::IDX_ENT0);
    if (!mapped(a))
      return 32'h0;
    if (i == ras_pkg::IDX_PTR)
      return {24'h0, s.global_irq_enable, 5'h0, s.sp};
    if (o[0])
      return {30'h0, s.hi[o[2:1]]};
    return {24'h0, s.lo[o[2:1]]};
  endfunction

  // decoded apb access
  logic [7:0] idx;        // register index
  logic [2:0] entOff;     // offset inside entry block
  logic       apbWr;      // write takes effect this edge
  assign idx    = paddr[9:2];
  assign entOff = 3'(idx - ras_pkg::IDX_ENT0);
  assign apbWr  = psel && penable && pwrite && mapped(paddr);

  // instruction cycle enable, one core clock long
  assign instrTick = (s_r.div == 8'(CYC_DIV - 1));

  // stack request decode, interrupt entry outranks call
  logic       pushEn;     // save counter this tick
  logic       popEn;      // restore counter this tick
  logic [9:0] pushVal;    // value saved
  logic [1:0] spDn;       // pointer after push
  logic [9:0] topVal;     // entry now at the top, shared with the checks
  assign pushEn  = irqEntry || callEn;
  assign popEn   = !pushEn && (retEn || retiEn);
  assign pushVal = irqEntry ? s_r.pc : 10'(s_r.pc + 10'h001);
  assign spDn    = 2'(s_r.sp - 2'h1);
  // one mux for the top entry, so pop logic and checks cannot drift apart
  assign topVal  = {s_r.hi[ras_pkg::entryOf(s_r.sp)], s_r.lo[ras_pkg::entryOf(s_r.sp)]};

  // next state
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.dmWe = 1'b0;
    s_nxt.dmRe = 1'b0;
    s_nxt.div  = instrTick ? 8'h00 : 8'(s_r.div + 8'h01);
    // read data is captured in the setup phase and stands through access
    if (psel && !penable)
      s_nxt.rdata = regRead(paddr, s_r);
    // software write; a stack operation in the same edge wins below
    if (apbWr)
    begin
      if (idx == ras_pkg::IDX_PTR)
      begin
        s_nxt.global_irq_enable = pwdata[ras_pkg::GIE_BIT];
        s_nxt.sp  = pwdata[ras_pkg::SP_W-1:0];
      end
      else if (entOff[0])
        s_nxt.hi[entOff[2:1]] = pwdata[ras_pkg::HI_W-1:0];
      else
        s_nxt.lo[entOff[2:1]] = pwdata[ras_pkg::LO_W-1:0];
    end
    // all core work happens once per instruction cycle
    if (instrTick)
    begin
      // finish a pending memory read
      if (s_r.accPend)
      begin
        s_nxt.acc     = memRdata;
        s_nxt.accPend = 1'b0;
      end
      // sequencer load overrides the read result
      if (accLoad)
        s_nxt.acc = accValue;
      if (pushEn)
      begin
        // move to the new top, then save there; a fifth push just wraps
        s_nxt.sp                             = spDn;
        s_nxt.hi[ras_pkg::entryOf(spDn)]     = pushVal[9:8];
        s_nxt.lo[ras_pkg::entryOf(spDn)]     = pushVal[7:0];
        s_nxt.pc                             = irqEntry ? IRQ_VEC : callTarget;
      end
      else if (popEn)
      begin
        // top entry back into the counter, last saved first out
        s_nxt.pc = topVal;
        s_nxt.sp = 2'(s_r.sp + 2'h1);
      end
      else if (jumpEn)
        s_nxt.pc = jumpTarget;
      else
        s_nxt.pc = 10'(s_r.pc + 10'h001);
      // data memory move
      if (memDirect || memIndirect)
      begin
        // direct is bank 0; indirect pairs bank and location
        s_nxt.dmAddr  = memDirect ? {ras_pkg::BANK0, directAddr} : {bankPtr, locPtr};
        s_nxt.dmWe    = memToMem;
        s_nxt.dmRe    = !memToMem;
        s_nxt.dmWdata = s_r.acc;
        s_nxt.accPend = !memToMem;
      end
    end
  end

  // reset loads constants only, so release cannot race a live value
  // state register; entries, enable and counter clear, pointer sets
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_r    <= '0;
      s_r.sp <= ras_pkg::SP_RST;
    end
    else
      s_r <= s_nxt;
  end

  // outputs
  assign prdata          = s_r.rdata;
  assign pready          = psel && penable;
  assign pslverr         = psel && penable && !mapped(paddr);
  assign programCounter  = s_r.pc;
  assign globalIrqEnable = s_r.global_irq_enable;
  assign dmAddr          = s_r.dmAddr;
  assign dmWe            = s_r.dmWe;
  assign dmRe            = s_r.dmRe;
  assign dmWdata         = s_r.dmWdata;
  assign accumulator     = s_r.acc;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  property p_push_dec;
    instrTick && pushEn |=> s_r.sp == 2'($past(s_r.sp) - 2'h1);
  endproperty
  a_push_dec: assert property (p_push_dec) else $error("push did not decrement pointer");

  property p_pop_inc;
    instrTick && popEn |=> s_r.sp == 2'($past(s_r.sp) + 2'h1);
  endproperty
  a_pop_inc: assert property (p_pop_inc) else $error("pop did not increment pointer");

  property p_call_save;
    instrTick && callEn && !irqEntry |=>
      topVal == 10'($past(s_r.pc) + 10'h001);
  endproperty
  a_call_save: assert property (p_call_save) else $error("call return address not saved");

  property p_irq_save;
    instrTick && irqEntry |=>
      topVal == $past(s_r.pc) && s_r.pc == IRQ_VEC;
  endproperty
  a_irq_save: assert property (p_irq_save) else $error("interrupt entry not saved");

  property p_pop_load;
    instrTick && popEn |=>
      s_r.pc == $past(topVal);
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("return did not load top entry");

  property p_wrap;
    instrTick && pushEn && s_r.sp == 2'h3 |=> s_r.sp == 2'h2;
  endproperty
  a_wrap: assert property (p_wrap) else $error("overflow push did not wrap");

  property p_pc_hold;
    !instrTick |=> $stable(s_r.pc);
  endproperty
  a_pc_hold: assert property (p_pc_hold) else $error("counter moved between ticks");

  property p_pc_inc;
    instrTick && !pushEn && !popEn && !jumpEn |=> s_r.pc == 10'($past(s_r.pc) + 10'h001);
  endproperty
  a_pc_inc: assert property (p_pc_inc) else $error("counter did not advance");

  property p_direct;
    instrTick && memDirect |=> dmAddr == {ras_pkg::BANK0, $past(directAddr)} && dmWe == $past(memToMem);
  endproperty
  a_direct: assert property (p_direct) else $error("direct address wrong");

  property p_indirect;
    instrTick && memIndirect && !memDirect |=> dmAddr == {$past(bankPtr), $past(locPtr)};
  endproperty
  a_indirect: assert property (p_indirect) else $error("indirect address wrong");

  property p_ptr_read;
    psel && !penable && paddr == {2'h0, ras_pkg::IDX_PTR, 2'h0} |=>
      prdata == {24'h0, $past(s_r.global_irq_enable), 5'h0, $past(s_r.sp)};
  endproperty
  a_ptr_read: assert property (p_ptr_read) else $error("pointer read wrong");

  // a stack operation never touches the enable bit, so a write always lands
  property p_gie_write;
    apbWr && idx == ras_pkg::IDX_PTR |=> s_r.global_irq_enable == $past(pwdata[ras_pkg::GIE_BIT]);
  endproperty
  a_gie_write: assert property (p_gie_write) else $error("enable bit not written");

  property p_rd_hold;
    psel && penable |=> $stable(prdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved after access");

  c_overflow: cover property (instrTick && pushEn && s_r.sp == 2'h3);
  c_call_ret: cover property (instrTick && callEn ##[1:200] instrTick && retEn);
  c_ptr_write: cover property (apbWr && idx == ras_pkg::IDX_PTR);
  c_mem_read: cover property (dmRe ##[1:20] instrTick && s_r.accPend);
  c_return_from_interrupt_pop: cover property (instrTick && retiEn && !pushEn);

endmodule
`default_nettype wire

/* testbench/data_mem_model.sv */
// behavioural data memory on the far side of the move path
`timescale 1ns/1ns
`default_nettype none
module data_mem_model (
  // clock
  input  wire logic        core_clk,
  // memory port of the block
  input  wire logic [15:0] dmAddr,
  input  wire logic        dmWe,
  input  wire logic [7:0]  dmWdata,
  output logic      [7:0]  memRdata
);
  logic [7:0] mem [0:255];  // bank is folded into the cell index
  // distinct seed values so a wrong address shows up
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i * 37 + 11);
  end
  // write strobe is taken at the clock edge
  always @(posedge core_clk)
  begin
    if (dmWe)
      mem[dmAddr[7:0] ^ dmAddr[15:8]] <= dmWdata;
  end
  // combinational read, valid well before the next tick
  assign memRdata = mem[dmAddr[7:0] ^ dmAddr[15:8]];
endmodule
`default_nettype wire

/* testbench/return_address_stack_bench.sv */
// self-checking bench for the return address stack
`timescale 1ns/1ns
`default_nettype none
module return_address_stack_bench;
  localparam logic [9:0] VEC = 10'h2A4;  // interrupt entry, arbitrary
  // design signals
  logic        core_clk, rstn, psel, penable, pwrite, pready, pslverr, instrTick;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic        irqEntry, callEn, retEn, retiEn, jumpEn, accLoad, memDirect, memIndirect, memToMem;
  logic [9:0]  callTarget, jumpTarget, programCounter;
  logic        globalIrqEnable, dmWe, dmRe;
  logic [7:0]  accValue, directAddr, bankPtr, locPtr, memRdata, dmWdata, accumulator, lf;
  logic [15:0] dmAddr;
  // reference model state
  logic [1:0]  mSp, e;
  logic [7:0]  mLo [4];
  logic [1:0]  mHi [4];
  logic [9:0]  mPc;
  logic [7:0]  mAcc;
  logic        mGie, pendRd;
  logic        tickSeen = 1'b0;
  logic        doCheck = 1'b0;
  int          error_cnt, comparisons;

  return_address_stack #(.CYC_DIV(2), .IRQ_VEC(VEC)) dut (.core_clk(core_clk), .rstn(rstn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .instrTick(instrTick), .irqEntry(irqEntry), .callEn(callEn), .callTarget(callTarget),
    .retEn(retEn), .retiEn(retiEn), .jumpEn(jumpEn), .jumpTarget(jumpTarget), .programCounter(programCounter),
    .globalIrqEnable(globalIrqEnable), .accLoad(accLoad), .accValue(accValue), .memDirect(memDirect),
    .memIndirect(memIndirect), .memToMem(memToMem), .directAddr(directAddr), .bankPtr(bankPtr),
    .locPtr(locPtr), .memRdata(memRdata), .dmAddr(dmAddr), .dmWe(dmWe), .dmRe(dmRe), .dmWdata(dmWdata),
    .accumulator(accumulator));
  data_mem_model mem (.core_clk(core_clk), .dmAddr(dmAddr), .dmWe(dmWe), .dmWdata(dmWdata), .memRdata(memRdata));

  // comparison and mismatch report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict and end of run
  task automatic close_out();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // random source for targets and data
  function automatic logic [7:0] nxt(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected register read from the model
  function automatic logic [31:0] mRead(input logic [11:0] a);
    if (a == 12'h37C)
      return {24'h0, mGie, 5'h0, mSp};
    if (a >= 12'h3C0 && a <= 12'h3DC)
      return a[2] ? 32'(mHi[a[4:3]]) : 32'(mLo[a[4:3]]);
    return 32'h0;
  endfunction

  // clock
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // watchdog, some sixty times the expected run
  initial
  begin
    #100000;
    error_cnt++;
    close_out();
  end
  // model: software write first, stack operation overrides it
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mSp = 2'h3;
      mGie = 1'b0;
      mPc = 10'h0;
      mAcc = 8'h0;
      pendRd = 1'b0;
      foreach (mLo[i])
        {mHi[i], mLo[i]} = 10'h0;
    end
    else
    begin
      if (psel && penable && pwrite && paddr == 12'h37C)
        {mGie, mSp} = {pwdata[7], pwdata[1:0]};
      else if (psel && penable && pwrite && paddr >= 12'h3C0 && paddr <= 12'h3DC)
        if (paddr[2])
          mHi[paddr[4:3]] = pwdata[1:0];
        else
          mLo[paddr[4:3]] = pwdata[7:0];
      if (tickSeen)
      begin
        doCheck = 1'b1;
        if (irqEntry || callEn)
        begin
          mSp = mSp - 2'h1;
          e = 2'(2'h2 - mSp);
          {mHi[e], mLo[e]} = irqEntry ? mPc : mPc + 10'h1;
          mPc = irqEntry ? VEC : callTarget;
        end
        else if (retEn || retiEn)
        begin
          e = 2'(2'h2 - mSp);
          mPc = {mHi[e], mLo[e]};
          mSp = mSp + 2'h1;
        end
        else
          mPc = jumpEn ? jumpTarget : mPc + 10'h1;
        if (accLoad)
          mAcc = accValue;
        else if (pendRd)
          mAcc = memRdata;
        pendRd = (memDirect || memIndirect) && !memToMem;
      end
    end
  end
  // outputs compared in mid-cycle after every instruction edge
  always @(negedge core_clk)
  begin
    if (doCheck)
    begin
      chk("programCounter", 32'(programCounter), 32'(mPc));
      chk("accumulator", 32'(accumulator), 32'(mAcc));
      chk("globalIrqEnable", 32'(globalIrqEnable), 32'(mGie));
    end
    doCheck = 1'b0;
    tickSeen = instrTick;
  end

  // one apb transfer, read data and error checked against the model
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    logic [11:0] a;
    logic [31:0] ex;
    a = 12'({idx, 2'b00});
    @(posedge core_clk);
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    psel <= 1'b1;
    @(negedge core_clk);
    ex = mRead(a);
    chk("pready", 32'(pready), 32'h0);
    @(posedge core_clk);
    penable <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    if (!wr)
      chk("prdata", prdata, ex);
    chk("pslverr", 32'(pslverr), 32'(a != 12'h37C && (a < 12'h3C0 || a > 12'h3DC)));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // one instruction: 1 irq, 2 call, 3 ret, 4 return_from_interrupt, 5 jump, 6 load, 7 direct store, 8 indirect read
  task automatic op(input int k, input logic [7:0] v);
    @(posedge core_clk);
    {irqEntry, callEn, retEn, retiEn, jumpEn} <= {k == 1, k == 2, k == 3, k == 4, k == 5};
    {accLoad, memDirect, memToMem, memIndirect} <= {k == 6, k == 7, k == 7, k == 8};
    {callTarget, jumpTarget} <= {v[1:0], v, v[1:0], v};
    {accValue, directAddr, bankPtr, locPtr} <= {v, v, v, ~v};
    @(negedge core_clk);
    while (instrTick !== 1'b1)
      @(negedge core_clk);
    @(posedge core_clk);
    {irqEntry, callEn, retEn, retiEn, jumpEn, accLoad, memDirect, memToMem, memIndirect} <= 9'h0;
    @(negedge core_clk);
  endtask

  // main sequence
  initial
  begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    {irqEntry, callEn, retEn, retiEn, jumpEn, accLoad, memDirect, memToMem, memIndirect} = 9'h0;
    {callTarget, jumpTarget, accValue, directAddr, bankPtr, locPtr} = '0;
    lf = 8'h5F;
    repeat (3) @(posedge core_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 10; i++)
      apb(1'b0, i == 0 ? 8'hDF : 8'(8'hEF + i), 32'h0);
    apb(1'b1, 8'hDF, 32'h83);
    apb(1'b0, 8'hDF, 32'h0);
    apb(1'b1, 8'hDF, 32'h03);
    for (int i = 0; i < 13; i++)
    begin
      lf = nxt(lf);
      op(i < 5 ? 1 + lf[0] : (i == 5 ? 5 : 3 + lf[0]), lf);
      apb(1'b0, 8'hDF, 32'h0);
      if (i == 4)
        for (int j = 0; j < 8; j++)
          apb(1'b0, 8'(8'hF0 + j), 32'h0);
    end
    lf = nxt(lf);
    apb(1'b1, 8'hF6, {24'h0, lf});
    apb(1'b1, 8'hF7, 32'h2);
    apb(1'b1, 8'hDF, 32'h3);
    op(3, 8'h0);
    lf = nxt(lf);
    op(6, lf);
    op(7, 8'hFF);
    chk("dmWe", 32'(dmWe), 32'h1);
    chk("dmAddr", 32'(dmAddr), 32'h00FF);
    chk("dmWdata", 32'(dmWdata), 32'(mAcc));
    op(8, lf);
    chk("dmRe", 32'(dmRe), 32'h1);
    chk("dmAddr", 32'(dmAddr), 32'({lf, ~lf}));
    op(0, 8'h0);
    op(8, nxt(lf));
    op(6, 8'h3C);
    close_out();
  end
endmodule
`default_nettype wire
